// ==== design/adcro_defs.svh ====
// Constants for the converter start and serial readout block
`ifndef ADCRO_DEFS_SVH
`define ADCRO_DEFS_SVH

// ----------------------------------------
// Word and readout lengths
// ----------------------------------------
`define ADCRO_WORD_W 16
`define ADCRO_FIFO_DEPTH 16
`define ADCRO_EDGES_PLAIN 5'h10
`define ADCRO_EDGES_BUSY 5'h11

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ADCRO_RST_OUT 1'b0
`define ADCRO_RST_OE_N 1'b1

// ----------------------------------------
// Conversion timing
// ----------------------------------------
`define ADCRO_CLK_MHZ 40
`define ADCRO_TCONV_MIN_NS 1500
`define ADCRO_TCONV_MAX_NS 3000
`define ADCRO_CONV_MIN_CYC (((`ADCRO_TCONV_MIN_NS * `ADCRO_CLK_MHZ) + 999) / 1000)
`define ADCRO_CONV_MAX_CYC ((`ADCRO_TCONV_MAX_NS * `ADCRO_CLK_MHZ) / 1000)

`endif

// ==== design/adcro_pkg.sv ====
// Types shared by the converter readout block
package adcro_pkg;

   typedef enum logic [1:0] {
      ST_ACQ = 2'b00,
      ST_CONV = 2'b01,
      ST_READ = 2'b10
   } adcro_state_t;

   typedef logic [15:0] adcro_word_t;

endpackage

// ==== design/adcro_fifo_if.sv ====
// Read side of the sample FIFO
`timescale 1ns/10ps
`default_nettype none

interface adcro_fifo_if #(parameter int WIDTH = 16);
   logic valid;
   logic ready;
   logic [WIDTH-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

`default_nettype wire

// ==== design/adcro_sync.sv ====
// Two-stage synchroniser for pin inputs
`timescale 1ns/10ps
`default_nettype none

module adcro_sync #(parameter int WIDTH = 3)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] din,
   output logic [WIDTH-1:0] dout
);
   logic [WIDTH-1:0] meta_q;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         meta_q <= '0;
         dout <= '0;
      end
      else
      begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule // adcro_sync

`default_nettype wire

// ==== design/adcro_fifo.sv ====
// Sample word FIFO with valid and ready on both sides
`timescale 1ns/10ps
`default_nettype none

module adcro_fifo #(parameter int WIDTH = 16, parameter int DEPTH = 16)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic wr_valid,
   output logic wr_ready,
   input wire logic [WIDTH-1:0] wr_data,
   adcro_fifo_if.src rd
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wp_q;
   logic [AW:0] rp_q;

   wire full = (wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]);
   wire empty = (wp_q == rp_q);
   wire push = wr_valid & ~full;
   wire pop = rd.ready & ~empty;

   assign wr_ready = ~full;
   assign rd.valid = ~empty;
   assign rd.data = mem[rp_q[AW-1:0]];

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wp_q <= '0;
         rp_q <= '0;
      end
      else
      begin
         if (push) wp_q <= wp_q + 1'b1;
         if (pop) rp_q <= rp_q + 1'b1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (push) mem[wp_q[AW-1:0]] <= wr_data;
   end
endmodule // adcro_fifo

`default_nettype wire

// ==== design/adcro_top.sv ====
// Conversion start, mode selection and serial readout of the converter
//
// Operation
// - Start edge with chain high: convert, float output
// - Select-mode conversion ignores later start edges
// - Busy enabled: output goes low at completion
// - Select busy: MSB first, float after 17 edges
// - Start and chain both low: output low except during select conversion or readout
// - Chain low presents MSB, float after 16
// - Chain low at start edge selects chain
// - Shift clock at start edge selects busy in chain mode
// - Chain mode always drives the output
// - Low output lets downstream pick chain mode
// - Chain no busy: MSB shown at completion
// - Falling shift edge shifts, loads chain bit
// - Chain tied to start selects chain mode
// - Busy passes on only when both done
// - Chain high selects select, low selects chain
// - Select busy if start or chain low
// - First edge does not pass busy bit
// - Start fall: shift high sleeps, low wakes
`include "adcro_defs.svh"
`timescale 1ns/10ps
`default_nettype none

module adcro_top
(
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic convert_start,
   input wire logic chain_input,
   input wire logic shift_clk,
   input wire adcro_pkg::adcro_word_t sample_data,
   input wire logic sample_valid,
   output logic sample_ready,
   output logic result_output,
   output logic result_oe_n,
   output logic powered_down
);
   import adcro_pkg::*;

   // ----------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------
   logic [2:0] pins_s;
   logic [2:0] pins_p_q;

   adcro_sync #(.WIDTH(3)) u_sync (
      .clk(ref_clk),
      .rst(sys_rst),
      .din({shift_clk, ~chain_input, convert_start}),
      .dout(pins_s)
   );

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst) pins_p_q <= 3'h0;
      else pins_p_q <= pins_s;
   end

   wire cnv_s = pins_s[0];
   // Chain pin kept inverted so reset matches its idle-high level
   wire chain_s = ~pins_s[1];
   wire sclk_s = pins_s[2];
   wire cnv_p = pins_p_q[0];
   wire chain_p = ~pins_p_q[1];
   wire sclk_p = pins_p_q[2];
   wire cnv_rise = cnv_s & ~cnv_p;
   wire cnv_fall = ~cnv_s & cnv_p;
   wire sclk_fall = ~sclk_s & sclk_p;
   wire both_low = ~cnv_s & ~chain_s;

   // ----------------------------------------
   // Sample FIFO
   // ----------------------------------------
   adcro_fifo_if #(.WIDTH(`ADCRO_WORD_W)) rd_if ();

   adcro_fifo #(.WIDTH(`ADCRO_WORD_W), .DEPTH(`ADCRO_FIFO_DEPTH)) u_fifo (
      .clk(ref_clk),
      .rst(sys_rst),
      .wr_valid(sample_valid),
      .wr_ready(sample_ready),
      .wr_data(sample_data),
      .rd(rd_if.src)
   );

   // ----------------------------------------
   // State
   // ----------------------------------------
   adcro_state_t state_q;
   logic [7:0] cnt_q;
   logic [4:0] edge_q;
   adcro_word_t shreg_q;
   logic chain_q;
   logic busy_en_q;
   logic busy_ph_q;
   logic drive_q;
   logic ind_q;
   logic sd_q;
   logic out_q;
   logic oe_n_q;

   localparam logic [7:0] CONV_LAST = 8'(`ADCRO_CONV_MAX_CYC - 1);

   // ----------------------------------------
   // Decodes
   // ----------------------------------------
   wire in_conv = (state_q == ST_CONV);
   wire in_read = (state_q == ST_READ);
   wire start = cnv_rise & ~sd_q & ~in_conv;
   wire pick_chain = ~chain_p;
   wire cnt_done = (cnt_q == CONV_LAST);
   wire conv_end = in_conv & cnt_done & rd_if.valid;
   wire sel_busy = ~cnv_s | ~chain_s;
   wire sel_open = in_read & ~chain_q & ~drive_q & sel_busy;
   wire shift_en = sclk_fall & in_read & (chain_q | drive_q);
   wire [4:0] edge_lim = busy_en_q ? `ADCRO_EDGES_BUSY : `ADCRO_EDGES_PLAIN;
   wire last_edge = shift_en & ~chain_q & (edge_q == edge_lim - 5'h01);
   wire sel_stop = last_edge | (cnv_rise & ~chain_q & in_read);
   wire ind_set = in_read & chain_q & busy_en_q & busy_ph_q & chain_s;
   wire shift_in = chain_q & chain_s;

   assign rd_if.ready = conv_end;

   wire [7:0] cnt_d = start ? 8'h00 : (in_conv & ~cnt_done) ? cnt_q + 8'h01 : cnt_q;
   wire [4:0] edge_d = (start | conv_end | sel_open) ? 5'h00 :
                       shift_en ? edge_q + 5'h01 : edge_q;
   wire adcro_state_t state_d = start ? ST_CONV :
                                conv_end ? ST_READ :
                                sel_stop ? ST_ACQ : state_q;

   // Busy bit is flushed by the first edge and not passed on
   wire adcro_word_t shreg_d = conv_end ? rd_if.data :
                               (shift_en & ~busy_ph_q) ? {shreg_q[14:0], shift_in} :
                               shreg_q;
   wire busy_ph_d = conv_end ? (chain_q ? busy_en_q : sel_busy) :
                    shift_en ? 1'b0 : busy_ph_q;
   wire busy_en_d = start ? (pick_chain & sclk_p) :
                    (conv_end & ~chain_q) ? sel_busy : busy_en_q;
   wire drive_d = (start | sel_stop) ? 1'b0 :
                  (conv_end & ~chain_q) ? sel_busy :
                  sel_open ? 1'b1 : drive_q;
   wire ind_d = (start | shift_en) ? 1'b0 : ind_set ? 1'b1 : ind_q;
   wire sd_d = cnv_fall ? sclk_p : sd_q;

   // ----------------------------------------
   // Output selection
   // ----------------------------------------
   wire chain_val = both_low ? 1'b0 :
                    ~in_read ? 1'b0 :
                    busy_ph_q ? ind_q : shreg_q[15];
   wire sel_val = (drive_q & ~busy_ph_q) ? shreg_q[15] : 1'b0;
   wire sel_drive = drive_q | (both_low & ~in_conv);
   wire out_d = chain_q ? chain_val : sel_val;
   wire oe_n_d = ~(chain_q | sel_drive);

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         state_q <= ST_ACQ;
         cnt_q <= 8'h00;
         edge_q <= 5'h00;
         shreg_q <= 16'h0000;
      end
      else
      begin
         state_q <= state_d;
         cnt_q <= cnt_d;
         edge_q <= edge_d;
         shreg_q <= shreg_d;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         chain_q <= 1'b0;
         busy_en_q <= 1'b0;
         busy_ph_q <= 1'b0;
         drive_q <= 1'b0;
      end
      else
      begin
         if (start) chain_q <= pick_chain;
         busy_en_q <= busy_en_d;
         busy_ph_q <= busy_ph_d;
         drive_q <= drive_d;
      end
   end

   always_ff @(posedge ref_clk or posedge sys_rst)
   begin
      if (sys_rst)
      begin
         ind_q <= 1'b0;
         sd_q <= 1'b0;
         out_q <= `ADCRO_RST_OUT;
         oe_n_q <= `ADCRO_RST_OE_N;
      end
      else
      begin
         ind_q <= ind_d;
         sd_q <= sd_d;
         out_q <= out_d;
         oe_n_q <= oe_n_d;
      end
   end

   assign result_output = out_q;
   assign result_oe_n = oe_n_q;
   assign powered_down = sd_q;

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   a_start_floats: assert property (
      start && chain_p |-> ##2 result_oe_n)
      else $error("select start did not float the output");

   a_conv_holds: assert property (
      in_conv && !conv_end |=> state_q == ST_CONV)
      else $error("conversion left before completion");

   a_busy_low: assert property (
      conv_end && !chain_q && sel_busy |-> ##2 (!result_oe_n && !result_output))
      else $error("busy indication not driven low");

   a_readout_stop: assert property (
      last_edge |=> (state_q == ST_ACQ && !drive_q))
      else $error("readout did not stop at the final edge");

   a_edge_limit: assert property (
      drive_q && !chain_q |-> edge_q < edge_lim)
      else $error("edge count passed its limit");

   a_both_low: assert property (
      both_low && !in_conv && !drive_q |=> (!result_oe_n && !result_output))
      else $error("both low did not drive the output low");

   a_mode_pick: assert property (
      start |=> chain_q == !$past(chain_p))
      else $error("mode not taken from chain input");

   a_busy_pick: assert property (
      start && pick_chain |=> busy_en_q == $past(sclk_p))
      else $error("chain busy option not taken from shift clock");

   a_chain_drives: assert property (
      chain_q |=> !result_oe_n)
      else $error("chain mode output floated");

   a_chain_msb: assert property (
      conv_end && chain_q && !busy_en_q |=> (shreg_q == $past(rd_if.data) && !busy_ph_q))
      else $error("chain result not loaded for output");

   a_chain_shift: assert property (
      shift_en && chain_q && !busy_ph_q
      |=> shreg_q == {$past(shreg_q[14:0]), $past(chain_s)})
      else $error("chain shift did not load upstream bit");

   a_ind_gate: assert property (
      $rose(ind_q) |-> $past(chain_s) && $past(in_read) && chain_q)
      else $error("indication passed without upstream indication");

   a_flush_first: assert property (
      shift_en && busy_ph_q |=> shreg_q == $past(shreg_q))
      else $error("busy bit edge shifted data");

   a_sleep_wake: assert property (
      cnv_fall |=> powered_down == $past(sclk_p))
      else $error("sleep state not set by shift clock level");

   a_sel_busy: assert property (
      conv_end && !chain_q |=> busy_en_q == $past(sel_busy))
      else $error("select busy choice wrong");

   a_conv_float: assert property (
      in_conv && !chain_q |=> result_oe_n)
      else $error("select conversion drove the output");

   a_float_stop: assert property (
      last_edge ##1 !both_low |=> result_oe_n)
      else $error("output not floated after final edge");

   a_sel_msb_out: assert property (
      drive_q && !chain_q && !busy_ph_q |=> !result_oe_n && result_output == $past(shreg_q[15]))
      else $error("select readout bit not driven");

   a_flush_clear: assert property (
      shift_en && busy_ph_q |=> !busy_ph_q)
      else $error("busy bit not flushed by first edge");

   a_sleep_refuse: assert property (
      cnv_rise && sd_q && !in_conv |=> !in_conv)
      else $error("conversion started while powered down");

   a_cnt_bound: assert property (
      in_conv |-> cnt_q <= CONV_LAST)
      else $error("conversion count past its end");

   a_refuse_rise: assert property (
      in_conv && cnv_rise && !cnt_done |=> cnt_q == $past(cnt_q) + 8'h01)
      else $error("start edge disturbed a running conversion");

   a_busy_msb: assert property (
      shift_en && busy_ph_q && !chain_q |-> ##2 result_output == $past(shreg_q[15], 2))
      else $error("first edge after busy did not show the top bit");

   a_chain_low_out: assert property (
      chain_q && both_low |=> !result_output && !result_oe_n)
      else $error("chain output not low with both pins low");

   a_ind_clear: assert property (
      chain_q && shift_en |=> !ind_q)
      else $error("indication kept after a shift edge");

   a_rise_stops: assert property (
      cnv_rise && in_read && !chain_q |=> !drive_q)
      else $error("start rise did not end select readout");

   c_chain_plain: cover property (conv_end && chain_q && !busy_en_q);
   c_chain_busy: cover property (ind_set ##[1:200] shift_en);
   c_sel_plain: cover property (last_edge && !busy_en_q);
   c_sel_busy: cover property (last_edge && busy_en_q);
   c_sleep: cover property (cnv_fall && sclk_p);

endmodule // adcro_top

`default_nettype wire

// ==== dv/adcro_host_model.sv ====
// Serial host that clocks frames out of the converter
`timescale 1ns/10ps
`default_nettype none

module adcro_host_model
(
   input wire logic go,
   input wire logic [5:0] n_falls,
   input wire logic idle_lvl,
   input wire logic result_output,
   input wire logic result_oe_n,
   output logic shift_clk,
   output logic done,
   output logic [31:0] cap
);
   logic sck;
   logic in_frame;
   wire logic line_lvl;

   // Released line reads high via pull-up
   assign line_lvl = result_oe_n ? 1'b1 : result_output;
   // Clock stands at idle level outside frames
   assign shift_clk = in_frame ? sck : idle_lvl;

   initial
   begin
      sck = 1'b0;
      in_frame = 1'b0;
      done = 1'b1;
      cap = '0;
   end

   always @(posedge go)
   begin
      done = 1'b0;
      cap = '0;
      #7;
      sck = idle_lvl;
      in_frame = 1'b1;
      repeat (n_falls)
      begin
         sck = 1'b1;
         #100;
         cap = {cap[30:0], line_lvl};
         sck = 1'b0;
         #100;
      end
      in_frame = 1'b0;
      done = 1'b1;
   end
endmodule // adcro_host_model

`default_nettype wire

// ==== dv/test_adc_conversion_readout_modes.sv ====
// Self-checking bench for the converter start and readout block
`timescale 1ns/10ps
`default_nettype none

module test_adc_conversion_readout_modes;
   import adcro_pkg::*;
   logic ref_clk;
   logic sys_rst;
   logic convert_start;
   logic chain_input;
   adcro_word_t sample_data;
   logic sample_valid;
   logic go;
   logic [5:0] n_falls;
   logic idle_lvl;
   wire logic shift_clk;
   wire logic sample_ready;
   wire logic result_output;
   wire logic result_oe_n;
   wire logic powered_down;
   wire logic done;
   wire logic [31:0] cap;
   int num_errors;
   int checked;
   logic [7:0] seq;
   adcro_word_t exp_q[$];

   adcro_top u_dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .convert_start(convert_start),
      .chain_input(chain_input), .shift_clk(shift_clk), .sample_data(sample_data),
      .sample_valid(sample_valid), .sample_ready(sample_ready),
      .result_output(result_output), .result_oe_n(result_oe_n),
      .powered_down(powered_down));

   adcro_host_model u_host (.go(go), .n_falls(n_falls), .idle_lvl(idle_lvl),
      .result_output(result_output), .result_oe_n(result_oe_n),
      .shift_clk(shift_clk), .done(done), .cap(cap));

   // ------
   // Helpers
   // ------
   task cyc(input int n);
      repeat (n) @(posedge ref_clk);
   endtask

   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
         num_errors++;
      end
   endtask

   task stop_test();
      if (num_errors == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task fill(input int n);
      adcro_word_t w;
      sample_valid <= 1'b1;
      repeat (n)
      begin
         seq++;
         w = 16'hc35a ^ {seq, ~seq};
         sample_data <= w;
         exp_q.push_back(w);
         cyc(1);
      end
      sample_valid <= 1'b0;
   endtask

   task shift(input int n);
      int k;
      n_falls <= 6'(n);
      go <= 1'b1;
      cyc(2);
      go <= 1'b0;
      k = 0;
      while (done !== 1'b1 && k < 2000)
      begin
         cyc(1);
         k++;
      end
      chk("host_done", done, 1'b1);
   endtask

   // ------
   // Scenarios
   // ------
   task conv_sel_plain();
      adcro_word_t w;
      w = exp_q.pop_front();
      chain_input <= 1'b1;
      convert_start <= 1'b0;
      cyc(4);
      convert_start <= 1'b1;
      cyc(8);
      chk("float_conv", result_oe_n, 1'b1);
      cyc(100);
      chk("float_mid", result_oe_n, 1'b1);
      cyc(30);
      chain_input <= 1'b0;
      cyc(6);
      chk("msb_drv", {result_oe_n, result_output}, {1'b0, w[15]});
      shift(16);
      chk("word_plain", cap, {16'h0, w});
      cyc(4);
      chk("float_end", result_oe_n, 1'b1);
   endtask

   task sleep_wake();
      idle_lvl <= 1'b1;
      cyc(6);
      convert_start <= 1'b0;
      cyc(6);
      chk("sleep", powered_down, 1'b1);
      idle_lvl <= 1'b0;
      cyc(6);
      convert_start <= 1'b1;
      cyc(6);
      chk("sleep_hold", powered_down, 1'b1);
      convert_start <= 1'b0;
      cyc(6);
      chk("wake", powered_down, 1'b0);
   endtask

   task conv_sel_busy(input logic four);
      adcro_word_t w;
      int k;
      w = exp_q.pop_front();
      chain_input <= 1'b1;
      cyc(6);
      convert_start <= 1'b1;
      cyc(8);
      if (four)
         chain_input <= 1'b0;
      else
         convert_start <= 1'b0;
      k = 0;
      while (result_oe_n !== 1'b0 && k < 300)
      begin
         cyc(1);
         k++;
      end
      chk("busy_low", {result_oe_n, result_output}, 2'b00);
      shift(17);
      chk("word_busy", cap, {15'h0, 1'b0, w});
      cyc(4);
      chk("float_end", result_oe_n, 1'b1);
   endtask

   task conv_chain(input logic busy);
      adcro_word_t w;
      w = exp_q.pop_front();
      convert_start <= 1'b0;
      chain_input <= 1'b0;
      cyc(6);
      chk("both_low", {result_oe_n, result_output}, 2'b00);
      idle_lvl <= busy;
      cyc(6);
      convert_start <= 1'b1;
      cyc(60);
      chk("chain_drv", result_oe_n, 1'b0);
      cyc(80);
      if (busy)
      begin
         chk("busy_wait", result_output, 1'b0);
         chain_input <= 1'b1;
         cyc(6);
         chk("busy_pass", result_output, 1'b1);
         shift(17);
         chk("chain_busy", cap, {15'h0, 1'b1, w});
      end
      else
      begin
         chk("chain_msb", result_output, w[15]);
         chain_input <= 1'b1;
         cyc(6);
         shift(32);
         chk("chain_word", cap, {w, 16'hffff});
      end
      chk("chain_hold", result_oe_n, 1'b0);
      idle_lvl <= 1'b0;
      cyc(6);
   endtask

   // ------
   // Main sequence
   // ------
   initial
   begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end

   initial
   begin
      cyc(30000);
      num_errors++;
      stop_test();
   end

   initial
   begin
      sys_rst = 1'b1;
      convert_start = 1'b0;
      chain_input = 1'b1;
      sample_data = '0;
      sample_valid = 1'b0;
      go = 1'b0;
      n_falls = '0;
      idle_lvl = 1'b0;
      num_errors = 0;
      checked = 0;
      seq = '0;
      cyc(8);
      sys_rst <= 1'b0;
      cyc(2);
      chk("reset", {result_oe_n, result_output, powered_down, sample_ready}, 4'b1001);
      fill(1);
      conv_sel_plain();
      sleep_wake();
      fill(1);
      conv_sel_busy(1'b0);
      fill(1);
      conv_sel_busy(1'b1);
      fill(2);
      conv_chain(1'b0);
      conv_chain(1'b1);
      fill(16);
      cyc(1);
      chk("full", sample_ready, 1'b0);
      sample_data <= 16'h0bad;
      sample_valid <= 1'b1;
      cyc(2);
      sample_valid <= 1'b0;
      repeat (16) conv_sel_plain();
      chk("empty", sample_ready, 1'b1);
      stop_test();
   end
endmodule // test_adc_conversion_readout_modes

`default_nettype wire
